// file: rtl/ssa_defs.svh
// constants for the subtract / and datapath
`ifndef SSA_DEFS_SVH
`define SSA_DEFS_SVH
// operation codes
`define SSA_OP_SUB 2'h0
`define SSA_OP_SUBTRACT_WITH_BORROW 2'h1
`define SSA_OP_AND 2'h2
// operand forms
`define SSA_F_IMM 3'h0
`define SSA_F_SADDR_IMM 3'h1
`define SSA_F_A_R 3'h2
`define SSA_F_R_A 3'h3
`define SSA_F_A_SADDR 3'h4
`define SSA_F_ABS 3'h5
`define SSA_F_HL 3'h6
`define SSA_F_HL_IDX 3'h7
// index kind for pointer forms
`define SSA_IDX_NONE 2'h0
`define SSA_IDX_BYTE 2'h1
`define SSA_IDX_B 2'h2
`define SSA_IDX_C 2'h3
// register numbers
`define SSA_R_X 3'h0
`define SSA_R_A 3'h1
`define SSA_R_C 3'h2
`define SSA_R_B 3'h3
`define SSA_R_E 3'h4
`define SSA_R_D 3'h5
`define SSA_R_L 3'h6
`define SSA_R_H 3'h7
// flags word bit positions
`define SSA_PSW_CY 0
`define SSA_PSW_BANK0 3
`define SSA_PSW_AC 4
`define SSA_PSW_BANK1 5
`define SSA_PSW_Z 6
`define SSA_PSW_IE 7
`define SSA_PSW_RESET 8'h02
`define SSA_HALF_BIT 4
// byte lengths and clock counts
`define SSA_LEN_1 3'h1
`define SSA_LEN_2 3'h2
`define SSA_LEN_3 3'h3
`define SSA_CLK_4 4'h4
`define SSA_CLK_5 4'h5
`define SSA_CLK_6 4'h6
`define SSA_CLK_8 4'h8
`define SSA_CLK_9 4'h9
`define SSA_CNT_ONE 4'h1
`endif

// file: rtl/ssa_pkg.sv
// types for the subtract / and datapath
package ssa_pkg;
    typedef enum logic [1:0] {
        SSA_IDLE = 2'h0,
        SSA_FETCH = 2'h1,
        SSA_EXEC = 2'h3,
        SSA_DONE = 2'h2
    } ssa_state_e;
    typedef struct packed {
        logic [7:0] value;
        logic half;
        logic carry;
        logic zero;
    } ssa_alu_s;
endpackage : ssa_pkg

// file: rtl/ssa_alu_if.sv
// operand and result bundle between the sequencer and the alu
`timescale 1ns/100ps
interface ssa_alu_if;
    logic [1:0] op;
    logic [7:0] lhs;
    logic [7:0] rhs;
    logic carry_in;
    ssa_pkg::ssa_alu_s res;
    modport seq (output op, output lhs, output rhs, output carry_in, input res);
    modport alu (input op, input lhs, input rhs, input carry_in, output res);
endinterface : ssa_alu_if

// file: rtl/ssa_alu.sv
// combinational subtract, subtract with borrow and and unit
`timescale 1ns/100ps
`include "ssa_defs.svh"
module ssa_alu
    import ssa_pkg::*;
(
    ssa_alu_if.alu bus
);
    logic [8:0] diff;
    logic [4:0] low;
    logic cin;
    // borrow-aware difference and low-nibble borrow
    always_comb begin
        cin = (bus.op == `SSA_OP_SUBTRACT_WITH_BORROW) ? bus.carry_in : 1'b0;
        diff = {1'b0, bus.lhs} - {1'b0, bus.rhs} - {8'h00, cin};
        low = {1'b0, bus.lhs[3:0]} - {1'b0, bus.rhs[3:0]} - {4'h0, cin};
        bus.res.value = (bus.op == `SSA_OP_AND) ? (bus.lhs & bus.rhs) : diff[7:0];
        bus.res.carry = diff[8];
        bus.res.half = low[`SSA_HALF_BIT];
        bus.res.zero = (bus.res.value == 8'h00);
    end
endmodule : ssa_alu

// file: rtl/ssa_core.sv
// instruction sequencer, register file and flags for sub / subtract_with_borrow / and
// Functional notes
// - eight byte registers A X B C D E H L, readable as four 16-bit pairs.
// - flags word holds zero, half carry, borrow, bank select and interrupt enable.
// - listed flags follow the result; unlisted flags keep their previous value.
// - sub immediate writes A, updates zero half and borrow; 2 bytes 4 clocks.
// - sub immediate from short-direct writes memory, all flags; 3 bytes 6/8 clocks.
// - sub absolute-addressed byte from A, all flags; 3 bytes 8/9 clocks.
// - sub pointer-addressed byte from A; 1 byte 4/5 clocks, all flags.
// - sub pointer plus byte offset; 2 bytes 8/9 clocks, all flags.
// - sub pointer plus B or C; 2 bytes 8/9 clocks, all flags.
// - subtract with borrow immediate also subtracts borrow; same length and clocks.
// - subtract with borrow short-direct immediate writes memory; 3 bytes 6/8 clocks.
// - and immediate writes A, zero only; 2 bytes 4 clocks.
// - and short-direct immediate writes memory, zero only; 3 bytes 6/8 clocks.
// - register forms 2 bytes 4 clocks; neither register form accepts A as the register operand.
// - short count for internal fast RAM or no data access, long count otherwise.
// - one instruction clock is one cpu clock period, internal program memory.
`timescale 1ns/100ps
`include "ssa_defs.svh"
module ssa_core
    import ssa_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [1:0] op_in,
    input wire logic [2:0] form_in,
    input wire logic [1:0] index_in,
    input wire logic [2:0] reg_sel_in,
    input wire logic [7:0] imm_in,
    input wire logic [15:0] abs_addr_in,
    input wire logic [15:0] saddr_in,
    input wire logic fast_ram_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [2:0] wr_sel_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic bank_wr_in,
    input wire logic [1:0] bank_in,
    input wire logic ie_wr_in,
    input wire logic ie_in,
    output logic busy_out,
    output logic done_out,
    output logic illegal_out,
    output logic [2:0] length_out,
    output logic [3:0] clocks_out,
    output logic mem_rd_out,
    output logic mem_wr_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic [7:0] acc_out,
    output logic [15:0] wide_accumulator_out,
    output logic [15:0] pair_bc_out,
    output logic [15:0] pair_de_out,
    output logic [15:0] pointer_pair_out,
    output logic [7:0] program_flags_word_out
);
    // ******************************
    // storage and state
    // ******************************
    logic [7:0] regs_reg [0:7];
    logic [7:0] regs_next [0:7];
    logic [7:0] psw_reg, psw_next;
    ssa_state_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] clocks_reg, clocks_next;
    logic [2:0] length_reg, length_next;
    logic [1:0] op_reg, op_next;
    logic [2:0] form_reg, form_next;
    logic [2:0] rsel_reg, rsel_next;
    logic [7:0] imm_reg, imm_next;
    logic [15:0] addr_reg, addr_next;
    logic rd_reg, rd_next;
    logic wr_reg, wr_next;
    logic [7:0] wdata_reg, wdata_next;
    logic done_reg, done_next;
    logic ill_reg, ill_next;
    logic [15:0] hl;
    logic [15:0] idx_addr;
    logic uses_mem;
    logic to_mem;
    logic to_reg;
    logic bad_form;
    ssa_alu_if alu_bus ();

    ssa_alu u_alu (
        .bus(alu_bus)
    );

    assign hl = {regs_reg[`SSA_R_H], regs_reg[`SSA_R_L]};

    // pointer-indexed address
    always_comb begin
        unique case (index_in)
            `SSA_IDX_BYTE: idx_addr = hl + {8'h00, imm_in};
            `SSA_IDX_B: idx_addr = hl + {8'h00, regs_reg[`SSA_R_B]};
            `SSA_IDX_C: idx_addr = hl + {8'h00, regs_reg[`SSA_R_C]};
            `SSA_IDX_NONE: idx_addr = hl;
        endcase
    end

    // operand kinds of the latched form; refusal check on the incoming form and register
    always_comb begin
        uses_mem = (form_reg == `SSA_F_SADDR_IMM) || (form_reg == `SSA_F_A_SADDR)
            || (form_reg == `SSA_F_ABS) || (form_reg == `SSA_F_HL)
            || (form_reg == `SSA_F_HL_IDX);
        to_mem = (form_reg == `SSA_F_SADDR_IMM);
        to_reg = (form_reg == `SSA_F_R_A);
        bad_form = ((form_in == `SSA_F_A_R) || (form_in == `SSA_F_R_A))
            && (reg_sel_in == `SSA_R_A);
    end

    // alu operand selection
    always_comb begin
        alu_bus.op = op_reg;
        alu_bus.carry_in = psw_reg[`SSA_PSW_CY];
        alu_bus.lhs = regs_reg[`SSA_R_A];
        alu_bus.rhs = imm_reg;
        unique case (form_reg)
            `SSA_F_IMM: alu_bus.rhs = imm_reg;
            `SSA_F_SADDR_IMM: begin
                alu_bus.lhs = mem_rdata_in;
                alu_bus.rhs = imm_reg;
            end
            `SSA_F_A_R: alu_bus.rhs = regs_reg[rsel_reg];
            `SSA_F_R_A: begin
                alu_bus.lhs = regs_reg[rsel_reg];
                alu_bus.rhs = regs_reg[`SSA_R_A];
            end
            `SSA_F_A_SADDR,
            `SSA_F_ABS,
            `SSA_F_HL,
            `SSA_F_HL_IDX: alu_bus.rhs = mem_rdata_in;
        endcase
    end

    // ******************************
    // sequencer next state
    // ******************************
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        clocks_next = clocks_reg;
        length_next = length_reg;
        op_next = op_reg;
        form_next = form_reg;
        rsel_next = rsel_reg;
        imm_next = imm_reg;
        addr_next = addr_reg;
        rd_next = 1'b0;
        wr_next = 1'b0;
        wdata_next = wdata_reg;
        done_next = 1'b0;
        ill_next = 1'b0;
        for (int i = 0; i < 8; i++) begin
            regs_next[i] = regs_reg[i];
        end
        psw_next = psw_reg;
        if (wr_en_in && (state_reg == SSA_IDLE)) begin
            regs_next[wr_sel_in] = wr_data_in;
        end
        if (bank_wr_in) begin
            psw_next[`SSA_PSW_BANK1] = bank_in[1];
            psw_next[`SSA_PSW_BANK0] = bank_in[0];
        end
        if (ie_wr_in) begin
            psw_next[`SSA_PSW_IE] = ie_in;
        end
        unique case (state_reg)
            SSA_IDLE: begin
                if (start_in && bad_form) begin
                    ill_next = 1'b1;
                end else if (start_in) begin
                    op_next = op_in;
                    form_next = form_in;
                    rsel_next = reg_sel_in;
                    imm_next = imm_in;
                    addr_next = 16'h0000;
                    unique case (form_in)
                        `SSA_F_IMM, `SSA_F_A_R, `SSA_F_R_A: begin
                            length_next = `SSA_LEN_2;
                            clocks_next = `SSA_CLK_4;
                        end
                        `SSA_F_SADDR_IMM: begin
                            length_next = `SSA_LEN_3;
                            clocks_next = fast_ram_in ? `SSA_CLK_6 : `SSA_CLK_8;
                            addr_next = saddr_in;
                        end
                        `SSA_F_A_SADDR: begin
                            length_next = `SSA_LEN_2;
                            clocks_next = fast_ram_in ? `SSA_CLK_4 : `SSA_CLK_5;
                            addr_next = saddr_in;
                        end
                        `SSA_F_ABS: begin
                            length_next = `SSA_LEN_3;
                            clocks_next = fast_ram_in ? `SSA_CLK_8 : `SSA_CLK_9;
                            addr_next = abs_addr_in;
                        end
                        `SSA_F_HL: begin
                            length_next = `SSA_LEN_1;
                            clocks_next = fast_ram_in ? `SSA_CLK_4 : `SSA_CLK_5;
                            addr_next = hl;
                        end
                        `SSA_F_HL_IDX: begin
                            length_next = `SSA_LEN_2;
                            clocks_next = fast_ram_in ? `SSA_CLK_8 : `SSA_CLK_9;
                            addr_next = idx_addr;
                        end
                    endcase
                    cnt_next = `SSA_CNT_ONE;
                    state_next = SSA_FETCH;
                end
            end
            SSA_FETCH: begin
                // one cpu clock per count; issue the data read
                cnt_next = cnt_reg + `SSA_CNT_ONE;
                rd_next = uses_mem;
                state_next = SSA_EXEC;
            end
            SSA_EXEC: begin
                cnt_next = cnt_reg + `SSA_CNT_ONE;
                if (cnt_reg == clocks_reg - `SSA_CNT_ONE) begin
                    if (to_mem) begin
                        wr_next = 1'b1;
                        wdata_next = alu_bus.res.value;
                    end else if (to_reg) begin
                        regs_next[rsel_reg] = alu_bus.res.value;
                    end else begin
                        regs_next[`SSA_R_A] = alu_bus.res.value;
                    end
                    psw_next[`SSA_PSW_Z] = alu_bus.res.zero;
                    if (op_reg != `SSA_OP_AND) begin
                        psw_next[`SSA_PSW_AC] = alu_bus.res.half;
                        psw_next[`SSA_PSW_CY] = alu_bus.res.carry;
                    end
                    state_next = SSA_DONE;
                end else begin
                    rd_next = uses_mem && rd_reg;
                end
            end
            SSA_DONE: begin
                done_next = 1'b1;
                state_next = SSA_IDLE;
            end
        endcase
    end

    // ******************************
    // registers
    // ******************************
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 8; i++) begin
                regs_reg[i] <= 8'h00;
            end
            psw_reg <= `SSA_PSW_RESET;
            state_reg <= SSA_IDLE;
            cnt_reg <= 4'h0;
            clocks_reg <= 4'h0;
            length_reg <= 3'h0;
            op_reg <= 2'h0;
            form_reg <= 3'h0;
            rsel_reg <= 3'h0;
            imm_reg <= 8'h00;
            addr_reg <= 16'h0000;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            wdata_reg <= 8'h00;
            done_reg <= 1'b0;
            ill_reg <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                regs_reg[i] <= regs_next[i];
            end
            psw_reg <= psw_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            clocks_reg <= clocks_next;
            length_reg <= length_next;
            op_reg <= op_next;
            form_reg <= form_next;
            rsel_reg <= rsel_next;
            imm_reg <= imm_next;
            addr_reg <= addr_next;
            rd_reg <= rd_next;
            wr_reg <= wr_next;
            wdata_reg <= wdata_next;
            done_reg <= done_next;
            ill_reg <= ill_next;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign busy_out = (state_reg != SSA_IDLE);
    assign done_out = done_reg;
    assign illegal_out = ill_reg;
    assign length_out = length_reg;
    assign clocks_out = clocks_reg;
    assign mem_rd_out = rd_reg;
    assign mem_wr_out = wr_reg;
    assign mem_addr_out = addr_reg;
    assign mem_wdata_out = wdata_reg;
    assign acc_out = regs_reg[`SSA_R_A];
    // pairs: high byte odd register, low byte even register
    assign wide_accumulator_out = {regs_reg[`SSA_R_A], regs_reg[`SSA_R_X]};
    assign pair_bc_out = {regs_reg[`SSA_R_B], regs_reg[`SSA_R_C]};
    assign pair_de_out = {regs_reg[`SSA_R_D], regs_reg[`SSA_R_E]};
    assign pointer_pair_out = hl;
    assign program_flags_word_out = psw_reg;
endmodule : ssa_core

// file: dv/ssa_mem_model.sv
// behavioural data memory beside the sequencer
`timescale 1ns/100ps
module ssa_mem_model (
    input wire logic clk_sys_in,
    input wire logic rd_in,
    input wire logic wr_in,
    input wire logic busy_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out = 8'hA5
);
    logic [7:0] mem [0:255];
    // write on pulse, answer a cycle after read, scramble once idle
    always @(posedge clk_sys_in) begin
        if (wr_in) begin
            mem[addr_in[7:0]] <= wdata_in;
        end
        if (rd_in) begin
            rdata_out <= mem[addr_in[7:0]];
        end else if (!busy_in) begin
            rdata_out <= ~rdata_out;
        end
    end
endmodule : ssa_mem_model

// file: dv/ssa_core_assertions.sv
// port checker for the sub / and sequencer
`timescale 1ns/100ps
module ssa_core_assertions (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [2:0] form_in,
    input wire logic [2:0] reg_sel_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic illegal_out,
    input wire logic [2:0] length_out,
    input wire logic [3:0] clocks_out,
    input wire logic mem_rd_out,
    input wire logic mem_wr_out,
    input wire logic [7:0] program_flags_word_out
);
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    logic [4:0] age_reg;
    logic [4:0] age_next;
    logic take;
    assign take = start_in && !busy_out;
    // cycles since the last taken start
    always_comb begin
        age_next = (age_reg == 5'h1F) ? age_reg : age_reg + 5'h01;
        if (take) begin
            age_next = 5'h01;
        end
    end
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            age_reg <= 5'h00;
        end else begin
            age_reg <= age_next;
        end
    end
    property p_done_time;
        done_out |-> age_reg == {1'b0, clocks_out} + 5'h01;
    endproperty
    a_done_time: assert property (p_done_time)
        else $error("done off its clock count");
    property p_done_one;
        done_out |=> !done_out;
    endproperty
    a_done_one: assert property (p_done_one)
        else $error("done longer than one cycle");
    property p_take;
        take |=> busy_out || illegal_out;
    endproperty
    a_take: assert property (p_take)
        else $error("start not taken");
    property p_illegal;
        take && form_in inside {3'h2, 3'h3} && reg_sel_in == 3'h1 |=> illegal_out;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("accumulator as register operand not refused");
    property p_flags_hold;
        !busy_out |=> $stable({program_flags_word_out[6], program_flags_word_out[4],
            program_flags_word_out[0]});
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flags moved while idle");
    property p_mem_busy;
        mem_rd_out || mem_wr_out |-> busy_out;
    endproperty
    a_mem_busy: assert property (p_mem_busy)
        else $error("memory access outside an instruction");
    property p_wr_once;
        mem_wr_out |=> !mem_wr_out;
    endproperty
    a_wr_once: assert property (p_wr_once)
        else $error("write pulse too long");
    property p_len1;
        done_out && length_out == 3'h1 |-> clocks_out inside {4'h4, 4'h5};
    endproperty
    a_len1: assert property (p_len1)
        else $error("one byte form with wrong count");
    c_done: cover property (done_out);
    c_illegal: cover property (illegal_out);
    c_write: cover property (mem_wr_out);
endmodule : ssa_core_assertions
bind ssa_core ssa_core_assertions chk_u (.clk_sys_in, .rst_in, .start_in, .form_in,
    .reg_sel_in, .busy_out, .done_out, .illegal_out, .length_out, .clocks_out, .mem_rd_out,
    .mem_wr_out, .program_flags_word_out);

// file: dv/sub_subtract_with_borrow_and_alu_ops_tb_top.sv
// self-checking bench for the sub / and sequencer
`timescale 1ns/100ps
module sub_subtract_with_borrow_and_alu_ops_tb_top import ssa_pkg::*;;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic start_in = 1'b0, fast_ram_in = 1'b0, wr_en_in = 1'b0;
    logic bank_wr_in = 1'b0, ie_wr_in = 1'b0, ie_in = 1'b0;
    logic [1:0] op_in = 2'h0, index_in = 2'h1, bank_in = 2'h0;
    logic [2:0] form_in = 3'h0, reg_sel_in = 3'h0, wr_sel_in = 3'h0, length_out;
    logic [7:0] imm_in = 8'h00, wr_data_in = 8'h00, mem_rdata_in, mem_wdata_out, acc_out;
    logic [15:0] abs_addr_in = 16'h0000, saddr_in = 16'h0000, mem_addr_out;
    logic busy_out, done_out, illegal_out, mem_rd_out, mem_wr_out;
    logic [3:0] clocks_out;
    logic [7:0] program_flags_word_out;
    logic [15:0] wide_accumulator_out, pair_bc_out, pair_de_out, pointer_pair_out;
    int r[8];
    int m[256];
    int cy = 0, ac = 0, z = 0, ie = 0, bk = 0;
    int fails = 0, samples_checked = 0, seed = 54;
    always #2.5 clk_sys_in = ~clk_sys_in;
    ssa_core dut_u (.clk_sys_in, .rst_in, .start_in, .op_in, .form_in, .index_in, .reg_sel_in,
        .imm_in, .abs_addr_in, .saddr_in, .fast_ram_in, .mem_rdata_in, .wr_sel_in, .wr_data_in,
        .wr_en_in, .bank_wr_in, .bank_in, .ie_wr_in, .ie_in, .busy_out, .done_out, .illegal_out,
        .length_out, .clocks_out, .mem_rd_out, .mem_wr_out, .mem_addr_out, .mem_wdata_out,
        .acc_out, .wide_accumulator_out, .pair_bc_out, .pair_de_out, .pointer_pair_out,
        .program_flags_word_out);
    ssa_mem_model mem_u (.clk_sys_in, .rd_in(mem_rd_out), .wr_in(mem_wr_out),
        .busy_in(busy_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
        .rdata_out(mem_rdata_in));
    // ************************************************************
    // compare, load and run tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_state();
        chk("acc", 16'(r[1]), {8'h00, acc_out});
        chk("ax", {8'(r[1]), 8'(r[0])}, wide_accumulator_out);
        chk("bc", {8'(r[3]), 8'(r[2])}, pair_bc_out);
        chk("de", {8'(r[5]), 8'(r[4])}, pair_de_out);
        chk("hl", {8'(r[7]), 8'(r[6])}, pointer_pair_out);
        chk("flags", {8'h00, ie[0], z[0], bk[1], ac[0], bk[0], 2'h1, cy[0]},
            {8'h00, program_flags_word_out});
    endtask : chk_state
    task automatic ld(input int s, input int v);
        @(negedge clk_sys_in);
        wr_sel_in = 3'(s);
        wr_data_in = 8'(v);
        wr_en_in = 1'b1;
        r[s] = v & 255;
        @(negedge clk_sys_in);
        wr_en_in = 1'b0;
    endtask : ld
    task automatic run(input int op, input int f, input int rs, input int fast);
        int lhs, rhs, c, res, ad, ck, ln, n, bad;
        logic ill;
        @(negedge clk_sys_in);
        op_in = 2'(op);
        form_in = 3'(f);
        reg_sel_in = 3'(rs);
        fast_ram_in = fast[0];
        imm_in = 8'($random(seed));
        abs_addr_in = 16'($random(seed));
        saddr_in = 16'($random(seed));
        index_in = 2'($random(seed));
        start_in = 1'b1;
        ad = (f == 1 || f == 4) ? saddr_in[7:0] : (f == 5) ? abs_addr_in[7:0] : r[6];
        if (f == 7) ad = (r[6] + ((index_in == 2'h0) ? 0 : (index_in == 2'h1) ? imm_in :
            r[index_in == 2'h2 ? 3 : 2])) & 255;
        rhs = (f < 2) ? imm_in : (f == 2) ? r[rs] : (f == 3) ? r[1] : m[ad];
        lhs = (f == 1) ? m[ad] : (f == 3) ? r[rs] : r[1];
        ck = (f == 0 || f == 2 || f == 3) ? 4 : (f == 1) ? (fast ? 6 : 8) :
            (f == 4 || f == 6) ? 4 + !fast : 8 + !fast;
        ln = (f == 6) ? 1 : (f == 1 || f == 5) ? 3 : 2;
        bad = (f == 2 || f == 3) && rs == 1;
        @(posedge clk_sys_in);
        // refusal pulse stands only in the cycle after the taking edge
        #1;
        ill = illegal_out;
        @(negedge clk_sys_in);
        start_in = 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
            #1;
        end while (done_out !== 1'b1 && ill !== 1'b1 && n < 20);
        chk("refused", 16'(bad), {15'h0000, ill});
        if (bad == 0) begin
            c = (op == 1) ? cy : 0;
            res = (op == 2) ? (lhs & rhs) : ((lhs - rhs - c) & 255);
            if (op != 2) begin
                cy = lhs < rhs + c;
                ac = (lhs & 15) < (rhs & 15) + c;
            end
            z = res == 0;
            if (f == 1) m[ad] = res;
            else if (f == 3) r[rs] = res;
            else r[1] = res;
            chk("cycles", 16'(ck), 16'(n));
            chk("clocks", 16'(ck), {12'h000, clocks_out});
            chk("length", 16'(ln), {13'h0000, length_out});
            if (f == 1) chk("memory", 16'(m[ad]), {8'h00, mem_u.mem[ad]});
        end
        while (busy_out !== 1'b0 && n < 40) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk_state();
    endtask : run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        for (int i = 0; i < 256; i++) begin
            m[i] = {$random(seed)} % 256;
            mem_u.mem[i] = 8'(m[i]);
        end
        for (int i = 0; i < 8; i++) r[i] = 0;
        repeat (6) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        chk_state();
        @(negedge clk_sys_in);
        bank_wr_in = 1'b1;
        bank_in = 2'h2;
        ie_wr_in = 1'b1;
        ie_in = 1'b1;
        bk = 2;
        ie = 1;
        @(negedge clk_sys_in);
        bank_wr_in = 1'b0;
        ie_wr_in = 1'b0;
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 8; i++) ld(i, (p == 0 && i == 1) ? 0 : $random(seed));
            for (int op = 0; op < 4; op++) begin
                for (int f = 0; f < 8; f++) run(op, f, ({$random(seed)} % 7 + 2) % 8, p % 2);
            end
        end
        run(0, 2, 1, 0);
        run(2, 3, 1, 1);
        end_of_test();
    end
    // watchdog well beyond the expected run length
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : sub_subtract_with_borrow_and_alu_ops_tb_top
